// ==== hw/hims_cfg.svh ====
// Constants for the home and index motion sequencer
// How it works
// - Homed-valid sets on successful home; clears on home start, encoder fault, reboot, unbacked power-down.
// - Any-home-done sets when a home finishes unstopped; clears on next home start.
// - Home-accelerating holds during ramp up and throughout sensor back-off.
// - Home-at-speed holds from target velocity until deceleration; never during back-off.
// - Home-done sets at end of deceleration, unless stopped; held until next start.
// - Home-busy holds from home start until all home motion ends.
// - Home-decelerating holds while slowing to zero and throughout sensor back-off.
// - Home-limit-hit sets when limit distance travelled without reference; held until restart.
// - Home starts on start rising edge; refused during index, jog, program, stop, travel limit.
// - Sensor edge latches position; debounce decides whether that edge counts.
// - Start with sensor active either backs off first or waits for next edge.
// - Five index types; incremental moves a set distance from current position.
// - Absolute picks direction from position; rotary types keep their fixed direction.
// - Registration runs until trigger, then travels the registration offset; with no trigger it stops at the limit.
// - Signed distance: incremental direction, absolute target, registration maximum travel.
// - Index velocity is unsigned and positive; never sets direction.
// - Timed index computes velocity and ramps covering distance in time, within maxima.
// - Sticky profile-limited set at start if maxima too low; run at maxima.
// - Timed-index time counts millisecond ticks, or master steps when synchronized.
// - Timed profile is triangular; accel to decel ratio equals ratio of maxima.
// - Limit-switch output turns on and off at unsigned start distances while running.
// - Off point beyond travel keeps the limit-switch output on until rerun.
// - Reference is sensor edge, marker edge, or first marker after sensor.
`ifndef HIMS_CFG_SVH
`define HIMS_CFG_SVH
`define HIMS_A_HCFG 8'h00
`define HIMS_A_HVEL 8'h04
`define HIMS_A_HACC 8'h08
`define HIMS_A_HDEC 8'h0c
`define HIMS_A_HLIM 8'h10
`define HIMS_A_ICFG 8'h14
`define HIMS_A_IDIST 8'h18
`define HIMS_A_IVEL 8'h1c
`define HIMS_A_IACC 8'h20
`define HIMS_A_IDEC 8'h24
`define HIMS_A_ITIME 8'h28
`define HIMS_A_ROFF 8'h2c
`define HIMS_A_ROLL 8'h30
`define HIMS_A_PLSON 8'h34
`define HIMS_A_PLSOFF 8'h38
`define HIMS_A_CMD 8'h3c
`define HIMS_A_STATUS 8'h40
`define HIMS_A_POS 8'h44
`define HIMS_HCFG_REF 1:0
`define HIMS_HCFG_BACKOFF 2
`define HIMS_HCFG_LIMEN 3
`define HIMS_ICFG_TYPE 2:0
`define HIMS_ICFG_TIMED 3
`define HIMS_ICFG_SYNC 4
`define HIMS_ICFG_PLSEN 5
`define HIMS_CMD_CLRPL 0
`define HIMS_REF_SENSOR 2'h0
`define HIMS_REF_MARKER 2'h1
`define HIMS_REF_SNS_MRK 2'h2
`define HIMS_RST_STATE '0
`define HIMS_CLK_PERIOD_NS 20
`define HIMS_TICK_MS 1
`define HIMS_TICK_CYC ((`HIMS_TICK_MS * 1000000) / `HIMS_CLK_PERIOD_NS)
`define HIMS_DEBOUNCE_CYC 16
`endif

// ==== hw/hims_pkg.sv ====
// Types for the home and index motion sequencer
package hims_pkg;
  typedef enum logic [2:0] {HIMS_IT_INCR, HIMS_IT_ABS, HIMS_IT_REG, HIMS_IT_ROTP, HIMS_IT_ROTM} hims_itype_e;
  typedef enum logic [2:0] {HIMS_S_IDLE, HIMS_S_CALC, HIMS_S_HBACK, HIMS_S_HSEEK, HIMS_S_IMOVE} hims_state_e;
  typedef enum logic [1:0] {HIMS_P_ACC, HIMS_P_RUN, HIMS_P_DEC} hims_phase_e;
  // Pins from the axis and machine, all asynchronous to pclk
  typedef struct packed {
    logic home_start;
    logic home_sensor_in;
    logic marker_in;
    logic index_start;
    logic reg_trigger_in;
    logic stop_in;
    logic travel_limit_in;
    logic jog_active;
    logic program_active;
    logic encoder_fault;
    logic power_down;
    logic aux_logic_supply;
    logic master_step;
  } hims_pins_s;
  typedef struct packed {
    logic homed_valid;
    logic any_home_done;
    logic home_accel;
    logic home_at_speed;
    logic home_decel;
    logic home_done_flag;
    logic home_busy_flag;
    logic home_limit_hit;
    logic index_accel;
    logic index_at_speed;
    logic index_decel;
    logic index_busy;
    logic index_done;
    logic profile_limited_flag;
    logic index_limit_switch_out;
  } hims_flags_s;
  typedef struct packed {
    hims_state_e st;
    hims_phase_e ph;
    logic dir;
    logic bnd;
    logic stopped;
    logic refd;
    logic armed;
    logic regseen;
    logic dpend;
    logic [15:0] ddeb;
    logic [31:0] vel, tgtv, acc, dec, rem, trav, tcnt, cv, ca;
    logic signed [31:0] pos, refpos, lpos;
    logic [63:0] dnum, dden, drem, dquo;
    logic [6:0] dcnt;
    logic [1:0] dstep;
    logic [4:0] hcfg;
    logic [5:0] icfg;
    logic [31:0] hvel, hacc, hdec, hlim, idist, ivel, iacc, idec, itime, roff, roll, plson, plsoff;
    hims_pins_s sy1, sy2, prv;
    logic [31:0] prdata;
    hims_flags_s fl;
  } hims_state_s;
endpackage : hims_pkg

// ==== hw/hims_seq.sv ====
// Home and index motion sequencer with APB register access
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`include "hims_cfg.svh"
module hims_seq #(
  parameter int TICK_CYC = `HIMS_TICK_CYC,
  parameter int DEB_CYC = `HIMS_DEBOUNCE_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire hims_pkg::hims_pins_s pins,
  output hims_pkg::hims_flags_s status,
  output logic signed [31:0] cmd_pos,
  output logic [31:0] cmd_vel,
  output logic cmd_dir
);

  hims_pkg::hims_state_s st_r;
  hims_pkg::hims_state_s st_nxt;
  logic [32:0] rd_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Register read decode, shared by read data and error answer
  function automatic logic [32:0] rd_word(input logic [7:0] a, input hims_pkg::hims_state_s s);
    logic [32:0] r;
    r = {1'b1, 32'h0};
    case (a)
      `HIMS_A_HCFG: r[31:0] = 32'(s.hcfg);
      `HIMS_A_HVEL: r[31:0] = s.hvel;
      `HIMS_A_HACC: r[31:0] = s.hacc;
      `HIMS_A_HDEC: r[31:0] = s.hdec;
      `HIMS_A_HLIM: r[31:0] = s.hlim;
      `HIMS_A_ICFG: r[31:0] = 32'(s.icfg);
      `HIMS_A_IDIST: r[31:0] = s.idist;
      `HIMS_A_IVEL: r[31:0] = s.ivel;
      `HIMS_A_IACC: r[31:0] = s.iacc;
      `HIMS_A_IDEC: r[31:0] = s.idec;
      `HIMS_A_ITIME: r[31:0] = s.itime;
      `HIMS_A_ROFF: r[31:0] = s.roff;
      `HIMS_A_ROLL: r[31:0] = s.roll;
      `HIMS_A_PLSON: r[31:0] = s.plson;
      `HIMS_A_PLSOFF: r[31:0] = s.plsoff;
      `HIMS_A_CMD: r[31:0] = 32'h0;
      `HIMS_A_STATUS: r[31:0] = 32'(s.fl);
      `HIMS_A_POS: r[31:0] = s.pos;
      default: r = 33'h0;
    endcase
    return r;
  endfunction : rd_word

  // Saturate a quotient to 32 bits so an oversized result reads as limited
  function automatic logic [31:0] sat32(input logic [63:0] q);
    return (|q[63:32]) ? 32'hffff_ffff : q[31:0];
  endfunction : sat32

  ////////////////////////////////////////////////////////////////////////////
  // Bus answers: zero wait states, unmapped addresses answer with an error
  assign pready = 1'b1;
  assign rd_sel = rd_word(paddr, st_r);
  assign pslverr = psel & penable & ~rd_sel[32];
  assign prdata = st_r.prdata;
  assign status = st_r.fl;
  assign cmd_pos = st_r.pos;
  assign cmd_vel = st_r.vel;
  assign cmd_dir = st_r.dir;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for the whole block
  always_comb begin
    hims_pkg::hims_pins_s rise;
    hims_pkg::hims_itype_e ityp;
    logic tick_rt, tick, fin, sens_ok, ref_hit, moving, stopc, lim, idle_ok;
    logic signed [31:0] refp, diff;
    logic [31:0] step, mag, q;
    logic [64:0] rsh;
    rise = st_r.sy2 & ~st_r.prv;
    ityp = hims_pkg::hims_itype_e'(st_r.icfg[`HIMS_ICFG_TYPE]);
    tick_rt = 1'b0;
    tick = 1'b0;
    fin = 1'b0;
    sens_ok = 1'b0;
    ref_hit = 1'b0;
    moving = 1'b0;
    stopc = 1'b0;
    lim = 1'b0;
    idle_ok = 1'b0;
    refp = st_r.pos;
    diff = 32'sh0;
    step = 32'h0;
    mag = 32'h0;
    q = 32'h0;
    rsh = 65'h0;
    st_nxt = st_r;

    // Two-stage synchroniser, then one stage of history for edges
    st_nxt.sy1 = pins;
    st_nxt.sy2 = st_r.sy1;
    st_nxt.prv = st_r.sy2;

    // Millisecond tick, or master steps for a synchronized index
    tick_rt = (st_r.tcnt >= 32'(TICK_CYC - 1));
    st_nxt.tcnt = tick_rt ? 32'h0 : st_r.tcnt + 32'h1;
    tick = (st_r.st == hims_pkg::HIMS_S_IMOVE && st_r.icfg[`HIMS_ICFG_SYNC]) ? rise.master_step : tick_rt;

    // Read capture in the setup phase, register writes in the access phase
    if (psel && !penable) begin
      st_nxt.prdata = rd_sel[31:0];
    end
    if (psel && penable && pwrite) begin
      case (paddr)
        `HIMS_A_HCFG: st_nxt.hcfg = pwdata[4:0];
        `HIMS_A_HVEL: st_nxt.hvel = pwdata;
        `HIMS_A_HACC: st_nxt.hacc = pwdata;
        `HIMS_A_HDEC: st_nxt.hdec = pwdata;
        `HIMS_A_HLIM: st_nxt.hlim = pwdata;
        `HIMS_A_ICFG: st_nxt.icfg = pwdata[5:0];
        `HIMS_A_IDIST: st_nxt.idist = pwdata;
        `HIMS_A_IVEL: st_nxt.ivel = pwdata;
        `HIMS_A_IACC: st_nxt.iacc = pwdata;
        `HIMS_A_IDEC: st_nxt.idec = pwdata;
        `HIMS_A_ITIME: st_nxt.itime = pwdata;
        `HIMS_A_ROFF: st_nxt.roff = pwdata;
        `HIMS_A_ROLL: st_nxt.roll = pwdata;
        `HIMS_A_PLSON: st_nxt.plson = pwdata;
        `HIMS_A_PLSOFF: st_nxt.plsoff = pwdata;
        `HIMS_A_CMD: if (pwdata[`HIMS_CMD_CLRPL]) st_nxt.fl.profile_limited_flag = 1'b0;
        default: st_nxt.prdata = st_r.prdata;
      endcase
    end

    // Sensor: latch position at the edge, accept it once debounced
    if (rise.home_sensor_in) begin
      st_nxt.lpos = st_r.pos;
      st_nxt.dpend = 1'b1;
      st_nxt.ddeb = 16'h0;
    end else if (st_r.dpend) begin
      if (!st_r.sy2.home_sensor_in) begin
        st_nxt.dpend = 1'b0;
      end else if (st_r.ddeb >= 16'(DEB_CYC)) begin
        sens_ok = 1'b1;
        st_nxt.dpend = 1'b0;
      end else begin
        st_nxt.ddeb = st_r.ddeb + 16'h1;
      end
    end

    // Home reference selection
    case (st_r.hcfg[`HIMS_HCFG_REF])
      `HIMS_REF_SENSOR: begin
        ref_hit = sens_ok;
        refp = st_r.lpos;
      end
      `HIMS_REF_MARKER: ref_hit = rise.marker_in;
      `HIMS_REF_SNS_MRK: ref_hit = st_r.armed & rise.marker_in;
      default: ref_hit = 1'b0;
    endcase
    if (st_r.st == hims_pkg::HIMS_S_HSEEK && sens_ok) begin
      st_nxt.armed = 1'b1;
    end

    // Homed state is lost on encoder fault or unbacked power-down
    if (st_r.sy2.encoder_fault || (st_r.sy2.power_down && !st_r.sy2.aux_logic_supply)) begin
      st_nxt.fl.homed_valid = 1'b0;
    end

    // Event handling in the moving states, checked before the ramp step
    moving = (st_r.st == hims_pkg::HIMS_S_HBACK) || (st_r.st == hims_pkg::HIMS_S_HSEEK) ||
             (st_r.st == hims_pkg::HIMS_S_IMOVE);
    if (moving && st_r.sy2.stop_in && !st_r.stopped) begin
      st_nxt.stopped = 1'b1;
      st_nxt.bnd = 1'b0;
      st_nxt.ph = hims_pkg::HIMS_P_DEC;
    end else if (st_r.st == hims_pkg::HIMS_S_HBACK && !st_r.sy2.home_sensor_in) begin
      st_nxt.ph = hims_pkg::HIMS_P_DEC;
    end else if (st_r.st == hims_pkg::HIMS_S_HSEEK && ref_hit && !st_r.refd) begin
      // Calculated offset: the reference ends the run and the ramp down follows
      st_nxt.refd = 1'b1;
      st_nxt.refpos = refp;
      st_nxt.bnd = 1'b0;
      st_nxt.ph = hims_pkg::HIMS_P_DEC;
    end else if (st_r.st == hims_pkg::HIMS_S_IMOVE && ityp == hims_pkg::HIMS_IT_REG &&
                 rise.reg_trigger_in && !st_r.regseen) begin
      st_nxt.regseen = 1'b1;
      st_nxt.rem = st_r.roff[31] ? 32'(-st_r.roff) : st_r.roff;
    end

    // Velocity ramp and position integration, one step per tick
    if (moving && tick) begin
      stopc = st_nxt.bnd && ((64'(st_nxt.rem) << 1) * 64'(st_r.dec) <= 64'(st_r.vel) * 64'(st_r.vel));
      unique case (st_nxt.ph)
        hims_pkg::HIMS_P_ACC: begin
          if (stopc) begin
            st_nxt.ph = hims_pkg::HIMS_P_DEC;
          end else if (33'(st_r.vel) + 33'(st_r.acc) >= 33'(st_r.tgtv)) begin
            st_nxt.vel = st_r.tgtv;
            st_nxt.ph = hims_pkg::HIMS_P_RUN;
          end else begin
            st_nxt.vel = st_r.vel + st_r.acc;
          end
        end
        hims_pkg::HIMS_P_RUN: if (stopc) st_nxt.ph = hims_pkg::HIMS_P_DEC;
        hims_pkg::HIMS_P_DEC: begin
          if (st_r.vel <= st_r.dec) begin
            st_nxt.vel = 32'h0;
            fin = 1'b1;
          end else begin
            st_nxt.vel = st_r.vel - st_r.dec;
          end
        end
      endcase
      // A bounded move lands exactly on its remaining distance
      if (st_nxt.bnd) begin
        step = (fin || st_nxt.rem < st_nxt.vel) ? st_nxt.rem : st_nxt.vel;
        st_nxt.rem = st_nxt.rem - step;
      end else begin
        step = st_nxt.vel;
      end
      st_nxt.pos = st_r.dir ? st_r.pos - $signed(step) : st_r.pos + $signed(step);
      st_nxt.trav = st_r.trav + step;
    end

    // End of each motion
    if (fin) begin
      unique case (st_r.st)
        hims_pkg::HIMS_S_HBACK: begin
          if (st_r.stopped) begin
            st_nxt.st = hims_pkg::HIMS_S_IDLE;
          end else begin
            st_nxt.st = hims_pkg::HIMS_S_HSEEK;
            st_nxt.ph = hims_pkg::HIMS_P_ACC;
            st_nxt.dir = ~st_r.dir;
            st_nxt.trav = 32'h0;
            st_nxt.bnd = st_r.hcfg[`HIMS_HCFG_LIMEN];
            st_nxt.rem = st_r.hlim;
          end
        end
        hims_pkg::HIMS_S_HSEEK: begin
          st_nxt.st = hims_pkg::HIMS_S_IDLE;
          if (!st_r.stopped) begin
            st_nxt.fl.home_done_flag = 1'b1;
            st_nxt.fl.any_home_done = 1'b1;
            if (st_r.refd) begin
              st_nxt.fl.homed_valid = 1'b1;
              st_nxt.pos = st_nxt.pos - st_r.refpos;
            end else begin
              st_nxt.fl.home_limit_hit = 1'b1;
            end
          end
        end
        hims_pkg::HIMS_S_IMOVE: begin
          st_nxt.st = hims_pkg::HIMS_S_IDLE;
          st_nxt.fl.index_done = !st_r.stopped;
        end
        default: st_nxt.st = hims_pkg::HIMS_S_IDLE;
      endcase
    end

    // Timed index: three shared divisions give velocity, accel and decel
    if (st_r.st == hims_pkg::HIMS_S_CALC) begin
      rsh = {st_r.drem, st_r.dnum[63]};
      if (rsh >= {1'b0, st_r.dden}) begin
        st_nxt.drem = 64'(rsh - {1'b0, st_r.dden});
        st_nxt.dquo = {st_r.dquo[62:0], 1'b1};
      end else begin
        st_nxt.drem = rsh[63:0];
        st_nxt.dquo = {st_r.dquo[62:0], 1'b0};
      end
      st_nxt.dnum = {st_r.dnum[62:0], 1'b0};
      st_nxt.dcnt = st_r.dcnt + 7'h1;
      if (st_r.dcnt == 7'h3f) begin
        q = sat32(st_nxt.dquo);
        st_nxt.dquo = 64'h0;
        st_nxt.drem = 64'h0;
        st_nxt.dcnt = 7'h0;
        st_nxt.dstep = st_r.dstep + 2'h1;
        st_nxt.dnum = 64'(st_r.dstep == 2'h0 ? q : st_r.cv) * (64'(st_r.iacc) + 64'(st_r.idec));
        st_nxt.dden = (st_r.dstep == 2'h0 ? 64'(st_r.idec) : 64'(st_r.iacc)) * 64'(st_r.itime);
        if (st_r.dstep == 2'h0) begin
          st_nxt.cv = q;
        end else if (st_r.dstep == 2'h1) begin
          st_nxt.ca = q;
        end else begin
          // Zero time or zero accel or decel maxima divide by zero and saturate into the limited case
          lim = (st_r.cv > st_r.ivel) || (st_r.ca > st_r.iacc) || (q > st_r.idec) || (st_r.cv == 32'h0);
          st_nxt.st = hims_pkg::HIMS_S_IMOVE;
          if (lim) begin
            st_nxt.fl.profile_limited_flag = 1'b1;
          end else begin
            st_nxt.tgtv = st_r.cv;
            st_nxt.acc = st_r.ca;
            st_nxt.dec = q;
          end
        end
      end
    end

    // Starts; home wins if both edges arrive together
    idle_ok = st_r.st == hims_pkg::HIMS_S_IDLE && !st_r.sy2.jog_active && !st_r.sy2.program_active &&
              !st_r.sy2.stop_in;
    if (rise.home_start && idle_ok && !st_r.sy2.travel_limit_in) begin
      st_nxt.fl.homed_valid = 1'b0;
      st_nxt.fl.any_home_done = 1'b0;
      st_nxt.fl.home_done_flag = 1'b0;
      st_nxt.fl.home_limit_hit = 1'b0;
      st_nxt.stopped = 1'b0;
      st_nxt.refd = 1'b0;
      st_nxt.armed = 1'b0;
      st_nxt.vel = 32'h0;
      st_nxt.ph = hims_pkg::HIMS_P_ACC;
      st_nxt.tgtv = st_r.hvel[31] ? 32'(-st_r.hvel) : st_r.hvel;
      st_nxt.acc = st_r.hacc;
      st_nxt.dec = st_r.hdec;
      st_nxt.trav = 32'h0;
      st_nxt.rem = st_r.hlim;
      if (st_r.sy2.home_sensor_in && st_r.hcfg[`HIMS_HCFG_BACKOFF]) begin
        st_nxt.st = hims_pkg::HIMS_S_HBACK;
        st_nxt.dir = ~st_r.hvel[31];
        st_nxt.bnd = 1'b0;
      end else begin
        st_nxt.st = hims_pkg::HIMS_S_HSEEK;
        st_nxt.dir = st_r.hvel[31];
        st_nxt.bnd = st_r.hcfg[`HIMS_HCFG_LIMEN];
      end
    end else if (rise.index_start && idle_ok) begin
      st_nxt.fl.index_done = 1'b0;
      st_nxt.fl.index_limit_switch_out = 1'b0;
      st_nxt.regseen = 1'b0;
      st_nxt.stopped = 1'b0;
      st_nxt.vel = 32'h0;
      st_nxt.ph = hims_pkg::HIMS_P_ACC;
      st_nxt.trav = 32'h0;
      st_nxt.bnd = 1'b1;
      st_nxt.tgtv = st_r.ivel;
      st_nxt.acc = st_r.iacc;
      st_nxt.dec = st_r.idec;
      unique case (ityp)
        hims_pkg::HIMS_IT_ABS: begin
          diff = st_r.idist - st_r.pos;
          st_nxt.dir = diff[31];
          mag = diff[31] ? 32'(-diff) : diff;
        end
        hims_pkg::HIMS_IT_ROTP: begin
          diff = st_r.idist - st_r.pos;
          st_nxt.dir = 1'b0;
          mag = diff[31] ? diff + st_r.roll : diff;
        end
        hims_pkg::HIMS_IT_ROTM: begin
          diff = st_r.pos - st_r.idist;
          st_nxt.dir = 1'b1;
          mag = diff[31] ? diff + st_r.roll : diff;
        end
        default: begin
          // Incremental and registration: sign gives direction, size the travel
          st_nxt.dir = st_r.idist[31];
          mag = st_r.idist[31] ? 32'(-st_r.idist) : st_r.idist;
        end
      endcase
      st_nxt.rem = mag;
      if (st_r.icfg[`HIMS_ICFG_TIMED] && ityp != hims_pkg::HIMS_IT_REG) begin
        st_nxt.st = hims_pkg::HIMS_S_CALC;
        st_nxt.dnum = 64'({mag, 1'b0});
        st_nxt.dden = 64'(st_r.itime);
        st_nxt.dquo = 64'h0;
        st_nxt.drem = 64'h0;
        st_nxt.dcnt = 7'h0;
        st_nxt.dstep = 2'h0;
      end else begin
        st_nxt.st = hims_pkg::HIMS_S_IMOVE;
      end
    end

    // Limit-switch output follows distance from start only while running
    if (st_r.st == hims_pkg::HIMS_S_IMOVE && st_r.icfg[`HIMS_ICFG_PLSEN]) begin
      st_nxt.fl.index_limit_switch_out = (st_nxt.trav >= st_r.plson) && (st_nxt.trav < st_r.plsoff);
    end

    // Phase flags, registered from the next state so they move with the event
    st_nxt.fl.home_busy_flag = (st_nxt.st == hims_pkg::HIMS_S_HBACK) || (st_nxt.st == hims_pkg::HIMS_S_HSEEK);
    st_nxt.fl.home_accel = (st_nxt.st == hims_pkg::HIMS_S_HBACK) ||
                           (st_nxt.st == hims_pkg::HIMS_S_HSEEK && st_nxt.ph == hims_pkg::HIMS_P_ACC);
    st_nxt.fl.home_at_speed = st_nxt.st == hims_pkg::HIMS_S_HSEEK && st_nxt.ph == hims_pkg::HIMS_P_RUN;
    st_nxt.fl.home_decel = (st_nxt.st == hims_pkg::HIMS_S_HBACK) ||
                           (st_nxt.st == hims_pkg::HIMS_S_HSEEK && st_nxt.ph == hims_pkg::HIMS_P_DEC);
    st_nxt.fl.index_busy = (st_nxt.st == hims_pkg::HIMS_S_IMOVE) || (st_nxt.st == hims_pkg::HIMS_S_CALC);
    st_nxt.fl.index_accel = st_nxt.st == hims_pkg::HIMS_S_IMOVE && st_nxt.ph == hims_pkg::HIMS_P_ACC;
    st_nxt.fl.index_at_speed = st_nxt.st == hims_pkg::HIMS_S_IMOVE && st_nxt.ph == hims_pkg::HIMS_P_RUN;
    st_nxt.fl.index_decel = st_nxt.st == hims_pkg::HIMS_S_IMOVE && st_nxt.ph == hims_pkg::HIMS_P_DEC;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reboot clears every flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= `HIMS_RST_STATE;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : hims_seq

// ==== verif/hims_seq_monitor.sv ====
// Port-level assertions for the home and index sequencer
`timescale 1ns/100ps
module hims_seq_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire hims_pkg::hims_pins_s pins,
  input wire hims_pkg::hims_flags_s status
);
  default clocking mon_cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Pins pass two sync flops and an edge stage, hence the delays below
  a_speed_not_ramp: assert property (!(status.home_at_speed && (status.home_accel || status.home_decel)))
    else $error("home at-speed overlaps a ramp flag");
  a_fault_clears: assert property (pins.encoder_fault [*4] |=> !status.homed_valid)
    else $error("homed flag survives encoder fault");
  a_done_ends_busy: assert property ($rose(status.home_done_flag) |-> $fell(status.home_busy_flag))
    else $error("home done without busy ending");
  a_any_with_done: assert property ($rose(status.any_home_done) |-> $rose(status.home_done_flag))
    else $error("any-home-done without home done");
  a_limit_not_valid: assert property ($rose(status.home_limit_hit) |-> !status.homed_valid)
    else $error("limit hit marked as homed");
  a_stop_refuses: assert property ($rose(status.home_busy_flag) |->
    !($past(pins.stop_in, 2) && $past(pins.stop_in, 3) && $past(pins.stop_in, 4)))
    else $error("home started while stopped");
  a_start_taken: assert property ($rose(pins.home_start) && !status.home_busy_flag && !status.index_busy
    && !pins.stop_in && !pins.travel_limit_in && !pins.jog_active && !pins.program_active
    |-> ##[2:5] status.home_busy_flag)
    else $error("home start not taken");
  a_pl_sticky: assert property (status.profile_limited_flag
    && !(psel && penable && pwrite && paddr == 8'h3c && pwdata[0]) |=> status.profile_limited_flag)
    else $error("profile limited dropped without clear");
endmodule : hims_seq_monitor
bind hims_seq hims_seq_monitor hims_seq_monitor_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pins(pins), .status(status));

// ==== verif/hims_axis_model.sv ====
// Axis model: encoder marker and home sensor seen from commanded position
`timescale 1ns/100ps
module hims_axis_model #(
  parameter int SENS_POS = 65536
) (
  input wire logic signed [31:0] cmd_pos,
  output logic marker_in,
  output logic home_sensor_in
);
  // Marker window is 8 units wide so an 8-unit step per tick cannot jump it
  assign marker_in = (cmd_pos[7:3] == 5'h00);
  assign home_sensor_in = (cmd_pos >= SENS_POS);
endmodule : hims_axis_model

// ==== verif/testbench.sv ====
// Self-checking bench for the home and index sequencer
`timescale 1ns/100ps
module testbench;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [31:0] x; logic err;} hims_row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, spd_seen, e, mk, sens, cmd_dir;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q, cmd_vel;
  logic signed [31:0] cmd_pos, p0;
  hims_pkg::hims_pins_s drv, pins;
  hims_pkg::hims_flags_s status;
  int error_cnt, tests_run, cyc;
  hims_row_s rows [6];
  hims_seq #(.TICK_CYC(4), .DEB_CYC(2)) hims_seq_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .status(status), .cmd_pos(cmd_pos), .cmd_vel(cmd_vel), .cmd_dir(cmd_dir));
  hims_axis_model hims_axis_model_inst (.cmd_pos(cmd_pos), .marker_in(mk), .home_sensor_in(sens));
  // Axis lines come from the model, the rest from the bench
  always_comb begin
    pins = drv;
    pins.marker_in = mk;
    pins.home_sensor_in = sens;
  end
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // Hang guard and at-speed watcher
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (status.home_at_speed === 1'b1) spd_seen <= 1'b1;
    if (cyc == 60000) begin
      error_cnt = error_cnt + 1;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // One APB transfer; an idle edge after it keeps drivers from double assignment
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  // Held four cycles so the synchroniser cannot miss it
  task automatic pulse(input int b);
    drv[b] <= 1'b1;
    repeat (4) @(posedge pclk);
    drv[b] <= 1'b0;
    @(posedge pclk);
  endtask : pulse
  task automatic wait_bit(input int b, input logic v);
    int n;
    n = 0;
    while (status[b] !== v && n < 20000) begin
      @(posedge pclk);
      n = n + 1;
    end
    chk(status[b], v);
  endtask : wait_bit
  task automatic summarize();
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, drv} = '0;
    {error_cnt, tests_run, cyc, spd_seen} = '0;
    rows = '{'{8'h04, 32'hfffffff8, 32'hfffffff8, 1'b0}, '{8'h10, 32'h12345678, 32'h12345678, 1'b0},
      '{8'h1c, 32'h5, 32'h5, 1'b0}, '{8'h3c, 32'h0, 32'h0, 1'b0}, '{8'h40, 32'hffffffff, 32'h0, 1'b0},
      '{8'h48, 32'h1, 32'h0, 1'b1}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(status, 15'h0);
    foreach (rows[i]) begin
      apb(1'b1, rows[i].a, rows[i].d);
      apb(1'b0, rows[i].a, 32'h0);
      chk(q, rows[i].x);
      chk(e, rows[i].err);
    end
    // Home to the marker, then a refused start and an encoder fault
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h04, 32'h8);
    apb(1'b1, 8'h08, 32'h2);
    apb(1'b1, 8'h0c, 32'h2);
    pulse(12);
    wait_bit(9, 1'b1);
    chk({status.homed_valid, status.any_home_done, status.home_busy_flag, spd_seen}, 4'hd);
    chk(cmd_vel, 32'h0);
    drv.stop_in <= 1'b1;
    repeat (3) @(posedge pclk);
    pulse(12);
    chk({status.home_busy_flag, status.home_done_flag}, 2'h1);
    drv.stop_in <= 1'b0;
    drv.encoder_fault <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(status.homed_valid, 1'b0);
    drv.encoder_fault <= 1'b0;
    // Sensor home cut short by stop: no completion flags
    apb(1'b1, 8'h00, 32'h0);
    pulse(12);
    wait_bit(8, 1'b1);
    repeat (40) @(posedge pclk);
    drv.stop_in <= 1'b1;
    wait_bit(8, 1'b0);
    chk({status.home_done_flag, status.any_home_done}, 2'h0);
    drv.stop_in <= 1'b0;
    // Limit distance travelled with the sensor out of reach
    apb(1'b1, 8'h00, 32'h8);
    apb(1'b1, 8'h10, 32'h12c);
    pulse(12);
    wait_bit(9, 1'b1);
    chk({status.home_limit_hit, status.homed_valid}, 2'h2);
    // Timed incremental index with maxima too low and off point past travel
    apb(1'b1, 8'h14, 32'h28);
    apb(1'b1, 8'h18, 32'hc8);
    apb(1'b1, 8'h28, 32'h2);
    apb(1'b1, 8'h1c, 32'h1);
    apb(1'b1, 8'h20, 32'h1);
    apb(1'b1, 8'h24, 32'h1);
    apb(1'b1, 8'h34, 32'ha);
    apb(1'b1, 8'h38, 32'h1f4);
    p0 = cmd_pos;
    pulse(9);
    wait_bit(2, 1'b1);
    chk(cmd_pos, p0 + 32'shc8);
    chk(cmd_dir, 1'b0);
    chk({status.profile_limited_flag, status.index_limit_switch_out}, 2'h3);
    apb(1'b1, 8'h3c, 32'h1);
    chk(status.profile_limited_flag, 1'b0);
    summarize();
  end
endmodule : testbench
